// [odc_serial_command.sv]
// Top of the octal DAC serial command block: pin sampling, shift register,
// chain output, DAC code and buffer mode storage, and a small register port.
// Assumes frame select, serial clock and serial data come straight from pins;
// the serial clock must be well below half the system clock rate.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module odc_serial_command
   import odc_pkg::*;
(
   // System
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             clkEn,
   // Serial link pins
   input  wire logic             frameSel_b,
   input  wire logic             serClk,
   input  wire logic             serIn,
   output var  logic             chainOut,
   output var  logic             chainOutEn,
   // Converter side
   output var  logic [7:0][7:0]  dacCode,
   output var  logic [3:0]       bufferOn,
   output var  logic [1:0]       fullBuffer,
   output var  logic             dacUpdate,
   output var  logic             modeUpdate,
   // Register port
   input  wire logic [7:0]       regAddr,
   input  wire logic [31:0]      regWdata,
   input  wire logic             regWr,
   input  wire logic             regRd,
   output var  logic [31:0]      regRdata
);

   typedef struct packed
   {
      logic             clkMeta;
      logic             clkSync;
      logic             clkPrev;
      logic             dinMeta;
      logic             dinSync;
      logic             selMeta;
      logic             selSync;
      logic             selPrev;
      odc_state_t       state;
      logic [15:0]      shiftReg;
      logic [4:0]       bitCount;
      logic [15:0]      frameWord;
      logic             latch;
      logic [7:0][7:0]  dacCode;
      logic [3:0]       bufferOn;
      logic [1:0]       fullBuffer;
      logic             dacUpdate;
      logic             modeUpdate;
      logic             chainOut;
      logic             chainOutEn;
      logic             chainEn;
      logic [4:0]       lastCount;
      logic             oddFlag;
      logic [31:0]      rdata;
   } odc_regs_t;

   odc_regs_t   q;
   odc_regs_t   next_q;
   odc_frame_if frm ();

   // True when the address hits one of the eight DAC readback words
   function automatic logic isDacAddr(input logic [7:0] addr);
      isDacAddr = (addr >= REG_DAC_BASE) && (addr <= REG_DAC_LAST) && (addr[1:0] == 2'b00);
   endfunction

   // Channel index of a DAC readback word
   function automatic logic [2:0] dacIndex(input logic [7:0] addr);
      logic [7:0] off;
      off      = addr - REG_DAC_BASE;
      dacIndex = off[4:2];
   endfunction

   odc_cmd_decode u_decode
   (
      .frm (frm.dec)
   );

   assign frm.word  = q.frameWord;
   assign frm.latch = q.latch;

   // Next-state logic for the whole block
   always_comb
   begin
      logic clkRise;
      logic selFall;
      logic selRise;
      logic oddSet;
      clkRise = 1'b0;
      selFall = 1'b0;
      selRise = 1'b0;
      oddSet  = 1'b0;
      next_q  = q;

      // Two flops on every pin; edges are taken from the second stage only
      next_q.clkMeta = serClk;
      next_q.clkSync = q.clkMeta;
      next_q.clkPrev = q.clkSync;
      next_q.dinMeta = serIn;
      next_q.dinSync = q.dinMeta;
      next_q.selMeta = frameSel_b;
      next_q.selSync = q.selMeta;
      next_q.selPrev = q.selSync;
      clkRise = q.clkSync & ~q.clkPrev;
      selFall = ~q.selSync & q.selPrev;
      selRise = q.selSync & ~q.selPrev;

      next_q.latch      = 1'b0;
      next_q.dacUpdate  = 1'b0;
      next_q.modeUpdate = 1'b0;

      // Link state machine
      case (q.state)
         ODC_IDLE:
         begin
            if (selFall)
            begin
               next_q.state    = ODC_FRAME;     // R10
               next_q.bitCount = 5'h00;
            end
         end
         ODC_FRAME:
         begin
            if (selRise)
            begin
               // Shifting stops here; the register keeps its last sixteen bits
               next_q.state     = ODC_IDLE;     // R16 R12
               next_q.frameWord = q.shiftReg;   // R18
               next_q.latch     = 1'b1;
               next_q.lastCount = q.bitCount;
               oddSet           = (q.bitCount != COUNT_FULL);
            end
            else if (clkRise)
            begin
               next_q.shiftReg = {q.shiftReg[14:0], q.dinSync};  // R2 R15
               if (q.bitCount != 5'h1f)
                  next_q.bitCount = q.bitCount + 5'h01;
            end
         end
         default:
         begin
            next_q.state = ODC_IDLE;
         end
      endcase

      // Open-drain chain output pulls low for a zero; the pin sees the bit
      // that is next to leave, so a chain behind sees the bit stream delayed by 16
      next_q.chainOut   = 1'b0;
      next_q.chainOutEn = q.chainEn & ~next_q.shiftReg[MASK_MSB];  // R17

      // Apply the decoded command the cycle after the latch pulse
      for (int ch = 0; ch < CHANNELS; ch++)
      begin
         if (frm.loadMask[ch])
            next_q.dacCode[ch] = frm.loadData;  // R3 R4
      end
      if (frm.loadMask != 8'h00)
         next_q.dacUpdate = 1'b1;
      if (frm.modeWrite)
      begin
         next_q.bufferOn   = frm.bufferOn;      // R5 R6
         next_q.fullBuffer = frm.fullBuffer;    // R7
         next_q.modeUpdate = 1'b1;
      end

      // Register writes; a new odd frame wins over a clear in the same cycle
      if (regWr)
      begin
         if (regAddr == REG_CTRL)
            next_q.chainEn = regWdata[CTRL_CHAIN_EN];
         if ((regAddr == REG_STATUS) && regWdata[STAT_ODD_FLAG])
            next_q.oddFlag = 1'b0;
      end
      if (oddSet)
         next_q.oddFlag = 1'b1;

      // Register reads: data stands for one cycle only
      next_q.rdata = 32'h0000_0000;
      if (regRd)
      begin
         if (regAddr == REG_CTRL)
            next_q.rdata[CTRL_CHAIN_EN] = q.chainEn;
         else if (regAddr == REG_STATUS)
         begin
            next_q.rdata[STAT_COUNT_LSB +: 5] = q.lastCount;
            next_q.rdata[STAT_ODD_FLAG]       = q.oddFlag;
            next_q.rdata[STAT_IN_FRAME]       = (q.state == ODC_FRAME);
         end
         else if (regAddr == REG_MODE)
         begin
            next_q.rdata[3:0]                 = q.bufferOn;
            next_q.rdata[MODE_FULL_LSB +: 2]  = q.fullBuffer;
         end
         else if (isDacAddr(regAddr))
            next_q.rdata[7:0] = q.dacCode[dacIndex(regAddr)];
      end
   end

   // State register: synchronous reset, frozen while the clock enable is low
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         q            <= '0;
         q.selMeta    <= 1'b1;
         q.selSync    <= 1'b1;
         q.selPrev    <= 1'b1;
         q.state      <= ODC_IDLE;
         q.dacCode    <= {CHANNELS{RESET_DAC_CODE}};
         q.bufferOn   <= RESET_BUF_ON;
         q.fullBuffer <= RESET_FULL_BUF;
         q.chainEn    <= RESET_CHAIN_EN;
      end
      else if (clkEn)
         q <= next_q;
   end

   // Outputs straight from the state register
   assign chainOut   = q.chainOut;
   assign chainOutEn = q.chainOutEn;
   assign dacCode    = q.dacCode;
   assign bufferOn   = q.bufferOn;
   assign fullBuffer = q.fullBuffer;
   assign dacUpdate  = q.dacUpdate;
   assign modeUpdate = q.modeUpdate;
   assign regRdata   = q.rdata;

endmodule : odc_serial_command
`default_nettype wire

// [odc_pkg.sv]
// Constants, field layouts and types for the octal DAC serial command block.
// Assumes a single 20 MHz system clock; the serial link pins are asynchronous to it.
//
// Overview of operation
// (R1) A command frame is 16 bits: an 8-bit channel mask, then a data byte.
// (R2) Bits shift in most significant first, mask MSB first, data LSB last.
// (R3) On latch, data loads every DAC channel whose mask bit is one.
// (R4) A nonzero-mask load changes only the selected DAC codes, never buffer modes.
// (R5) Zero mask with command flag set: skip bit six, store six mode bits only.
// (R6) Mode bits five, four, two, one enable buffering of pairs 0-1, 2-3, 4-5, 6-7.
// (R7) Bit three picks full or half buffer for outputs 0-3, bit zero for 4-7.
// (R8) An all-zero frame is the idle command and changes nothing.
// (R9) In a chain the host sends idle frames to devices that must not change.
// (R10) Frame select going low starts a new command frame.
// (R11) A byte host sends mask byte then data byte under one frame select.
// (R12) Frame select returning high makes the device apply the latched command.
// (R13) The host keeps serial data valid around each rising serial clock edge.
// (R14) The host shifts each byte out most significant bit first.
// (R15) Serial input is sampled on each rising serial clock while frame select is low.
// (R16) Frame select rising latches the 16 bits, stops shifting, applies the command.
// (R17) Shifted-out bits leave on an open-drain chain output for the next device.
// (R18) With other than sixteen bits, the last sixteen shifted in are decoded.
package odc_pkg;

   // Frame layout
   localparam int unsigned FRAME_BITS     = 16;
   localparam int unsigned CHANNELS       = 8;
   localparam int unsigned MASK_MSB       = 15;
   localparam int unsigned MASK_LSB       = 8;
   localparam int unsigned DATA_MSB       = 7;
   localparam int unsigned DATA_LSB       = 0;

   // Data byte fields of a buffer command
   localparam int unsigned BUFFER_CMD_FLAG        = 7;
   localparam int unsigned IGNORED_BIT            = 6;
   localparam int unsigned PAIR01_BUFFER_ON       = 5;
   localparam int unsigned PAIR23_BUFFER_ON       = 4;
   localparam int unsigned LOW_GROUP_FULL_BUFFER  = 3;
   localparam int unsigned PAIR45_BUFFER_ON       = 2;
   localparam int unsigned PAIR67_BUFFER_ON       = 1;
   localparam int unsigned HIGH_GROUP_FULL_BUFFER = 0;

   // Register port map (byte addresses)
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_MODE     = 8'h08;
   localparam logic [7:0] REG_DAC_BASE = 8'h10;
   localparam logic [7:0] REG_DAC_LAST = 8'h2c;

   // Register fields
   localparam int unsigned CTRL_CHAIN_EN   = 0;
   localparam int unsigned STAT_COUNT_LSB  = 0;
   localparam int unsigned STAT_ODD_FLAG   = 8;
   localparam int unsigned STAT_IN_FRAME   = 9;
   localparam int unsigned MODE_FULL_LSB   = 4;

   // Reset values
   localparam logic [7:0]  RESET_DAC_CODE  = 8'h00;
   localparam logic [3:0]  RESET_BUF_ON    = 4'h0;
   localparam logic [1:0]  RESET_FULL_BUF  = 2'h0;
   localparam logic        RESET_CHAIN_EN  = 1'b1;
   localparam logic [4:0]  COUNT_FULL      = 5'h10;

   // Link timing as seen by the bench
   localparam int unsigned SYS_CLK_NS      = 50;
   localparam int unsigned LINK_PERIOD_NS  = 400;
   localparam int unsigned SAMPLES_PER_BIT = LINK_PERIOD_NS / SYS_CLK_NS;

   // Link state, one-hot
   typedef enum logic [1:0]
   {
      ODC_IDLE  = 2'b01,
      ODC_FRAME = 2'b10
   } odc_state_t;

endpackage : odc_pkg

// [odc_frame_if.sv]
// Carrier between the serial front end and the command decoder.
// Assumes both ends run on the same clock; the decoder is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface odc_frame_if;
   logic [15:0] word;       // Last sixteen bits shifted in
   logic        latch;      // One-cycle pulse: frame closed
   logic [7:0]  loadMask;   // Channels to load this cycle
   logic [7:0]  loadData;   // Code for the selected channels
   logic        modeWrite;  // Buffer mode update this cycle
   logic [3:0]  bufferOn;   // Pair buffer enables
   logic [1:0]  fullBuffer; // Group full/half choice
   logic        idle;       // Idle command seen

   modport src
   (
      output word, latch,
      input  loadMask, loadData, modeWrite, bufferOn, fullBuffer, idle
   );
   modport dec
   (
      input  word, latch,
      output loadMask, loadData, modeWrite, bufferOn, fullBuffer, idle
   );
endinterface : odc_frame_if
`default_nettype wire

// [odc_cmd_decode.sv]
// Command decoder: turns a latched frame into load and mode actions.
// Assumes latch is a one-cycle pulse and word is stable while it is high.
`timescale 1ns/1ps
`default_nettype none
module odc_cmd_decode
   import odc_pkg::*;
(
   // Frame carrier
   odc_frame_if.dec frm
);

   logic [7:0] mask;
   logic [7:0] data;

   // Split the frame into mask and data byte
   assign mask = frm.word[MASK_MSB:MASK_LSB];        // R1
   assign data = frm.word[DATA_MSB:DATA_LSB];

   // Classify the command; bit six is never looked at
   always_comb
   begin
      frm.loadMask   = 8'h00;
      frm.loadData   = data;
      frm.modeWrite  = 1'b0;
      frm.idle       = 1'b0;
      frm.bufferOn   = {data[PAIR67_BUFFER_ON], data[PAIR45_BUFFER_ON],
                        data[PAIR23_BUFFER_ON], data[PAIR01_BUFFER_ON]};          // R6
      frm.fullBuffer = {data[HIGH_GROUP_FULL_BUFFER], data[LOW_GROUP_FULL_BUFFER]}; // R7
      if (frm.latch)
      begin
         if (mask != 8'h00)
            frm.loadMask = mask;                     // R3 R4
         else if (data[BUFFER_CMD_FLAG])
            frm.modeWrite = 1'b1;                    // R5
         else
            frm.idle = 1'b1;                         // R8
      end
   end

endmodule : odc_cmd_decode
`default_nettype wire

// [odc_serial_command_properties.sv]
// Port-level checks for the octal DAC serial command block.
// Assumes one clock domain and a host that keeps frame select high for at least 6 clk.
`timescale 1ns/1ps
`default_nettype none
module odc_serial_command_properties
(
   // System
   input wire logic            clk,
   input wire logic            rst_b,
   // Link and register port
   input wire logic            frameSel_b,
   input wire logic            regRd,
   input wire logic [31:0]     regRdata,
   input wire logic            chainOut,
   // Converter side
   input wire logic [7:0][7:0] dacCode,
   input wire logic [3:0]      bufferOn,
   input wire logic [1:0]      fullBuffer,
   input wire logic            dacUpdate,
   input wire logic            modeUpdate
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Update pulses are single cycles and never of both kinds
   load_pulse_a: assert property (dacUpdate |=> !dacUpdate) else $error("load pulse too long");
   mode_pulse_a: assert property (modeUpdate |=> !modeUpdate) else $error("mode pulse too long");
   one_kind_a: assert property (!(dacUpdate && modeUpdate)) else $error("load and mode at once");
   // Stored state moves only with its own pulse, so idle frames change nothing
   code_hold_a: assert property ($changed(dacCode) |-> dacUpdate) else $error("code moved alone");
   mode_hold_a: assert property ($changed({bufferOn, fullBuffer}) |-> modeUpdate) else $error("mode moved alone");
   mode_keeps_a: assert property (modeUpdate |-> $stable(dacCode)) else $error("mode write hit codes");
   // Commands apply only after the pin has been high a while
   after_close_a: assert property ((dacUpdate || modeUpdate) |-> frameSel_b && $past(frameSel_b, 3))
      else $error("command applied inside frame");
   read_quiet_a: assert property (!$past(regRd) |-> regRdata == 32'h0) else $error("stray read data");
   chain_low_a: assert property (chainOut == 1'b0) else $error("chain output drives high");

   // Main scenarios
   load_seen_c: cover property (dacUpdate);
   mode_seen_c: cover property (modeUpdate);
   read_seen_c: cover property (regRd ##1 regRdata != 32'h0);
endmodule // odc_serial_command_properties
`default_nettype wire

// [odc_host_model.sv]
// Behavioural host: a serial master sending frames on the link pins.
// Assumes the block samples data on rising serial clock; clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module odc_host_model
(
   // Link pins toward the block
   output var logic frameSel_b,
   output var logic serClk,
   output var logic serIn
);
   localparam time HALF = 200;

   // Pins idle with no frame open
   initial
   begin
      frameSel_b = 1'b1;
      serClk     = 1'b0;
      serIn      = 1'b0;
   end

   // Sends the low n bits of w, first bit first; offset keeps pin edges off clk edges
   task automatic send(input logic [23:0] w, input int n);
      #13;
      frameSel_b = 1'b0;
      #HALF;
      for (int i = n - 1; i >= 0; i--)
      begin
         serIn = w[i];
         #HALF serClk = 1'b1;
         #HALF serClk = 1'b0;
      end
      serIn = ~serIn; // No stale bit left on a released line
      #HALF frameSel_b = 1'b1;
      #(3 * HALF);
   endtask
endmodule // odc_host_model
`default_nettype wire

// [tb.sv]
// Self-checking bench for the octal DAC serial command block.
// Assumes the host model drives the link and the bench drives the register port.
`timescale 1ns/1ps
`default_nettype none
module tb
   import odc_pkg::*;
   ;
   logic            clk;
   logic            rst_b = 1'b0;
   logic            clkEn = 1'b1;
   logic            regWr = 1'b0;
   logic            regRd = 1'b0;
   logic            rdSeen = 1'b0;
   logic            frameSel_b, serClk, serIn, chainOut, chainOutEn, dacUpdate, modeUpdate;
   logic [7:0][7:0] dacCode;
   logic [7:0][7:0] eDac = '0;
   logic [3:0]      bufferOn;
   logic [3:0]      eOn = 4'h0;
   logic [1:0]      fullBuffer;
   logic [1:0]      eFull = 2'h0;
   logic [7:0]      regAddr = 8'h00;
   logic [31:0]     regWdata = 32'h0;
   logic [31:0]     regRdata;
   logic [69:0]     sq[$];
   logic [31:0]     rq[$];
   logic [7:0]      modes [4] = '{8'hff, 8'hc0, 8'hb6, 8'hc9};
   int              failures = 0;
   int              tests_run = 0;
   int              cycles = 0;
   integer          seed = 32'hfd5b;

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   odc_serial_command i_odc_serial_command
   (
      .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .frameSel_b(frameSel_b), .serClk(serClk), .serIn(serIn),
      .chainOut(chainOut), .chainOutEn(chainOutEn), .dacCode(dacCode), .bufferOn(bufferOn),
      .fullBuffer(fullBuffer), .dacUpdate(dacUpdate), .modeUpdate(modeUpdate), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata)
   );
   odc_host_model i_odc_host_model (.frameSel_b(frameSel_b), .serClk(serClk), .serIn(serIn));

   task automatic check(input logic [69:0] seen, input logic [69:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Notes the expected state, then sends; idle frames note nothing
   task automatic frame(input logic [23:0] w, input int n);
      logic [7:0] m;
      logic [7:0] d;
      m = w[15:8];
      d = w[7:0];
      for (int i = 0; i < 8; i++)
         if (m[i]) eDac[i] = d;
      if (m == 8'h00 && d[7])
      begin
         eOn = {d[1], d[2], d[4], d[5]};
         eFull = {d[0], d[3]};
      end
      if (m != 8'h00 || d[7]) sq.push_back({eDac, eOn, eFull});
      i_odc_host_model.send(w, n);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      rq.push_back(e);
      @(posedge clk);
      regRd   <= 1'b0;
   endtask

   // Read marker and hang guard
   always @(posedge clk)
   begin
      rdSeen <= regRd;
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         complete_run();
      end
   end

   // Results are taken mid-cycle, once settled, against the oldest note
   always @(negedge clk)
   begin
      if (rdSeen) check(70'(regRdata), 70'(rq.pop_front()));
      if (dacUpdate || modeUpdate) check({dacCode, bufferOn, fullBuffer}, sq.pop_front());
   end

   initial
   begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rd(REG_CTRL, 32'h1);
      rd(REG_MODE, 32'h0);
      rd(REG_DAC_BASE, 32'h0);
      wr(8'h40, 32'hff);
      rd(8'h40, 32'h0);
      $display("test reset done");
      // Each channel alone, all eight, then random masks
      for (int i = 0; i < 8; i++) frame({8'h0, 8'h1 << i, 8'($random(seed))}, 16);
      frame({8'h0, 8'hff, 8'($random(seed))}, 16);
      repeat (6) frame({8'h0, 8'($random(seed)) | 8'h01, 8'($random(seed))}, 16);
      for (int i = 0; i < 8; i++) rd(REG_DAC_BASE + 8'(4 * i), {24'h0, eDac[i]});
      $display("test loads done");
      // Four buffer modes, each mode bit set and clear, bit six set and clear
      foreach (modes[j])
      begin
         frame({16'h0, modes[j]}, 16);
         rd(REG_MODE, {26'h0, eFull, eOn});
      end
      $display("test modes done");
      frame(24'h0, 16);
      frame(24'h35, 16);
      rd(REG_MODE, {26'h0, eFull, eOn});
      frame(24'h0f0433, 20);
      rd(REG_STATUS, 32'h114);
      wr(REG_STATUS, 32'h100);
      frame(24'h8277, 16);
      rd(REG_STATUS, 32'h010);
      check(70'(chainOutEn), 70'(1'b0));
      // Status read while the frame is still open shows the in-frame bit
      fork
         frame(24'h015a, 16);
         begin
            repeat (40) @(posedge clk);
            rd(REG_STATUS, 32'h210);
         end
      join
      check(70'(chainOutEn), 70'(1'b1));
      // A write made while the clock enable is low must not land
      clkEn <= 1'b0;
      wr(REG_CTRL, 32'h0);
      clkEn <= 1'b1;
      rd(REG_CTRL, 32'h1);
      wr(REG_CTRL, 32'h0);
      // The enable drops one edge after the write lands; look once it has settled
      repeat (2) @(negedge clk);
      check(70'(chainOutEn), 70'(1'b0));
      $display("test frames done");
      repeat (5) @(posedge clk);
      complete_run();
   end
endmodule // tb

bind odc_serial_command odc_serial_command_properties i_odc_serial_command_properties
(
   .clk(clk), .rst_b(rst_b), .frameSel_b(frameSel_b), .regRd(regRd), .regRdata(regRdata), .chainOut(chainOut),
   .dacCode(dacCode), .bufferOn(bufferOn), .fullBuffer(fullBuffer), .dacUpdate(dacUpdate), .modeUpdate(modeUpdate)
);
`default_nettype wire
